// ---- dv/mr_ctrl_model.sv ----
/*
  Controller model: drives mode register set, read and write commands.
  Assumes a single caller; each task starts from a deselected bus.
*/
`timescale 1ns/1ps
`default_nettype none
module mr_ctrl_model
(
  // Clock
  input  wire logic                     i_clk,
  // Command pins
  output logic                          o_cs_b,
  output logic                          o_ras_b,
  output logic                          o_cas_b,
  output logic                          o_we_b,
  output logic [2:0]                    o_ba,
  output logic [ddr_mr_pkg::ADDR_W-1:0] o_addr
);
  import ddr_mr_pkg::*;

  initial
  begin
    o_cs_b  = 1'b1;
    o_ras_b = 1'b1;
    o_cas_b = 1'b1;
    o_we_b  = 1'b1;
    o_ba    = 3'h0;
    o_addr  = '0;
  end

  // One command cycle, then deselect with bank and address inverted
  task automatic issue(input logic [3:0] pins, input logic [2:0] bank, input logic [ADDR_W-1:0] a);
    @(posedge i_clk);
    {o_cs_b, o_ras_b, o_cas_b, o_we_b} <= pins;
    o_ba   <= bank;
    o_addr <= a;
    @(posedge i_clk);
    o_cs_b <= 1'b1;
    o_ba   <= ~bank;
    o_addr <= ~a;
  endtask

  task automatic mrs0(input logic [ADDR_W-1:0] v);
    issue(4'h0, MRS_BANK_MR0, v & 15'h1F7F);
  endtask

  task automatic mrs1(input logic [ADDR_W-1:0] v);
    logic [ADDR_W-1:0] m;
    m = v & ~MR1_RSVD_MASK;
    if ({m[9], m[6], m[2]} > RTT_WRITE_MAX)
      m[9] = 1'b0;
    issue(4'h0, MRS_BANK_MR1, m);
  endtask

  task automatic rw(input logic wr, input logic [ADDR_W-1:0] a);
    issue({3'b010, ~wr}, 3'h0, a);
  endtask
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
/*
  Bench for the mode-register decode block: register view, mode loads,
  burst order, latencies and DLL tracking against a bench model.
  Assumes the package and the controller model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ddr_mr_pkg::*;
  logic              clk, rst_b, sr, pd, psel, pen, pwr, er;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              pready, pslverr, valid, dq_oe, wref, dll_rst, dll_on;
  logic              locked, pd_fast, tm, tse, wl, cs_b, ras_b, cas_b, we_b;
  logic [2:0]        col, ba;
  logic [ADDR_W-1:0] addr, m0, m1;
  logic [LAT_W-1:0]  rl, dal;
  int                num_errors, total_checks, bl, cl, al, rlv, dv, n;
  int                wrt[8] = '{16, 5, 6, 7, 8, 10, 12, 14};

  mr_ctrl_model mr_ctrl_model_i (.i_clk(clk), .o_cs_b(cs_b), .o_ras_b(ras_b), .o_cas_b(cas_b),
    .o_we_b(we_b), .o_ba(ba), .o_addr(addr));

  sdram_mode_register_decode sdram_mode_register_decode_i (
    .I_CLK_SYS(clk), .I_RST_B(rst_b), .I_CE(1'b1), .I_CS_B(cs_b), .I_RAS_B(ras_b),
    .I_CAS_B(cas_b), .I_WE_B(we_b), .I_BA(ba), .I_ADDR(addr), .I_SELF_REFRESH(sr),
    .I_PWR_DOWN(pd), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .O_BEAT_COL(col), .O_BEAT_VALID(valid), .O_DQ_OE(dq_oe), .O_WRITE_REF(wref),
    .O_DLL_RESET(dll_rst), .O_DLL_ON(dll_on), .O_DLL_LOCKED(locked), .O_PD_FAST_EXIT(pd_fast),
    .O_TEST_MODE(tm), .O_TERM_STROBE_EN(tse), .O_WRITE_LEVEL(wl), .O_READ_LATENCY(rl),
    .O_DAL_CYCLES(dal));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic limit(input logic ok);
    if (ok !== 1'b1)
    begin
      num_errors++;
      close_out();
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    limit(pready === 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rd);
    chk("pslverr", 32'h0000_0000, 32'(er));
  endtask

  function automatic int expcol(input logic w, input int s, input int i, input logic chop);
    if (w)
      return chop ? (s & 4) | i : i;
    if (m0[3])
      return s ^ i;
    return ((s ^ i) & 4) | ((s + i) & 3);
  endfunction

  task automatic burst(input logic w, input logic [2:0] s, input logic c12);
    int k, rs, nb;
    nb = (bl == BL_FIXED4 || (bl == BL_OTF && !c12)) ? 4 : 8;
    rs = -1;
    k = 0;
    mr_ctrl_model_i.rw(w, {2'b00, c12, 9'h000, s});
    do
    begin
      @(negedge clk);
      k++;
    end while (valid !== 1'b1 && k < 60);
    limit(valid === 1'b1);
    chk("latency", w ? 32'd2 : 32'(rlv), 32'(k));
    for (int j = 0; j < 8; j++)
    begin
      if (j > 0)
        @(negedge clk);
      if (wref === 1'b1)
        rs = j;
      chk("beat_valid", 32'(j < nb), 32'(valid));
      chk("dq_oe", 32'(!w && j < nb && !m1[12]), 32'(dq_oe));
      if (j < nb)
        chk("beat_col", 32'(expcol(w, s, j, nb == 4)), 32'(col));
    end
    chk("write_ref", w ? (bl == BL_FIXED4 ? 32'd5 : 32'd7) : '1, 32'(rs));
  endtask

  initial
  begin
    {rst_b, sr, pd, psel, pen, pwr} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    void'($urandom(20));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rreg(OFF_CTRL, 32'h0000_0001, "ctrl");
    rreg(OFF_MR1, 32'h0000_0000, "mr1");
    rreg(OFF_LAT, 32'h1604_0004, "lat");
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {rd[30:0], er});
    apb(1'b1, OFF_MR0, 32'h0000_1234);
    apb(1'b1, OFF_CTRL, 32'h0000_0000);
    mr_ctrl_model_i.mrs0(15'h0031);
    rreg(OFF_MR0, 32'h0000_0000, "mr0_gated");
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    sr <= 1'b1;
    repeat (4) @(posedge clk);
    chk("dll_on_sr", 32'h0000_0000, 32'(dll_on));
    sr <= 1'b0;
    repeat (4) @(posedge clk);
    chk("dll_on_back", 32'h0000_0001, 32'(dll_on));
    for (int p = 0; p < 2; p++)
    begin
      mr_ctrl_model_i.mrs0(15'(p << 12));
      repeat (4) @(posedge clk);
      pd <= 1'b1;
      repeat (4) @(posedge clk);
      chk("dll_on_pd", 32'(p), 32'(dll_on));
      chk("pd_fast", 32'(p), 32'(pd_fast));
      pd <= 1'b0;
      repeat (4) @(posedge clk);
    end
    // DLL enable, then reset, then wait for lock before any read
    mr_ctrl_model_i.mrs1(15'h0000);
    mr_ctrl_model_i.mrs0(15'h0100);
    n = 0;
    while (dll_rst !== 1'b1 && n < 8)
    begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (dll_rst === 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    chk("dll_rst_len", 32'h1, 32'(n >= DLL_RESET_CYCLES - 1 && n <= DLL_RESET_CYCLES + 1));
    n = 0;
    while (locked !== 1'b1 && n < 700)
    begin
      @(negedge clk);
      n++;
    end
    chk("lock_time", 32'h1, 32'(n >= DLL_LOCK_CYCLES - 2 && n <= DLL_LOCK_CYCLES + 4));
    rreg(OFF_MR0, 32'h0000_0000, "mr0_selfclr");
    for (int it = 0; it < 24; it++)
    begin
      m0 = (15'($urandom) & 15'h1E74) | 15'(((it / 3) % 2) * 8) | 15'(it % 3);
      m1 = 15'($urandom) & 15'h18FE;
      // First pass pinned to a read latency of five
      if (it == 0)
      begin
        m0[6:4] = 3'h1;
        m0[2]   = 1'b0;
        m1[4:3] = 2'h0;
      end
      mr_ctrl_model_i.mrs1(m1);
      mr_ctrl_model_i.mrs0(m0);
      repeat (4) @(posedge clk);
      bl = m0[1:0];
      cl = 4 + m0[6:4] + (m0[2] ? 8 : 0);
      al = m1[4:3] == AL_CL1 ? cl - 1 : m1[4:3] == AL_CL2 ? cl - 2 : 0;
      rlv = al + cl;
      dv = wrt[m0[11:9]] + 6;
      rreg(OFF_LAT, 32'(cl | al << 8 | rlv << 16 | dv << 24), "lat");
      rreg(OFF_MR0, 32'(m0), "mr0");
      rreg(OFF_MR1, 32'(m1), "mr1");
      apb(1'b0, OFF_STATUS, 32'h0000_0000);
      chk("status_al", 32'({1'b0, m1[4:3] == AL_RSVD, 6'h03}), 32'(rd[7:0]));
      chk("rl_out", 32'(rlv), 32'(rl));
      chk("dal_out", 32'(dv), 32'(dal));
      chk("mode_bits", 32'({m0[12], m1[11], m1[7], 1'b0}), 32'({pd_fast, tse, wl, tm}));
      burst(it[0], 3'($urandom), 1'($urandom));
      repeat (2) @(posedge clk);
      burst(!it[0], 3'($urandom), 1'($urandom));
      repeat (2) @(posedge clk);
    end
    close_out();
  end
endmodule
`default_nettype wire

// ---- rtl/burst_col_order.sv ----
/*
  Column order generator: column address of one burst beat.
  Assumes the caller steps the beat index once per clock.
*/
`timescale 1ns/1ps
`default_nettype none
module burst_col_order
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_ce,
  // Beat request
  input  wire logic [2:0] i_start,
  input  wire logic [2:0] i_beat,
  input  wire logic       i_interleave,
  input  wire logic       i_write,
  input  wire logic       i_chop,
  // Result
  output logic      [2:0] o_col
);
  logic [2:0] seq_col;
  logic [2:0] rd_col;
  logic [2:0] wr_col;
  logic [2:0] col_next;

  assign seq_col  = {i_start[2] ^ i_beat[2], i_start[1:0] + i_beat[1:0]};
  assign rd_col   = i_interleave ? (i_start ^ i_beat) : seq_col;
  assign wr_col   = i_chop ? {i_start[2], i_beat[1:0]} : i_beat;
  assign col_next = i_write ? wr_col : rd_col;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_col <= 3'h0;
    else if (i_ce)
      o_col <= col_next;
  end
endmodule
`default_nettype wire

// ---- rtl/ddr_mr_pkg.sv ----
/*
  Constants and decode helpers for the mode-register decode block.
  Assumes a single 50 MHz system clock; counts below are in its cycles.
*/
package ddr_mr_pkg;
  localparam int ADDR_W  = 15;
  localparam int LAT_W   = 6;
  localparam int PADDR_W = 8;

  // Register byte offsets
  localparam logic [PADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [PADDR_W-1:0] OFF_MR0    = 8'h04;
  localparam logic [PADDR_W-1:0] OFF_MR1    = 8'h08;
  localparam logic [PADDR_W-1:0] OFF_STATUS = 8'h0C;
  localparam logic [PADDR_W-1:0] OFF_LAT    = 8'h10;

  // Reset values
  localparam logic              CTRL_EN_RESET = 1'h1;
  localparam logic [ADDR_W-1:0] MR_RESET      = 15'h0000;

  // Mode register 0 fields
  localparam int MR0_BL_LSB  = 0;
  localparam int MR0_CL_LO   = 2;
  localparam int MR0_BT      = 3;
  localparam int MR0_CL_LSB  = 4;
  localparam int MR0_TM      = 7;
  localparam int MR0_DLLRST  = 8;
  localparam int MR0_WR_LSB  = 9;
  localparam int MR0_PPD     = 12;
  localparam int CMD_CHOP    = 12;

  // Mode register 1 fields
  localparam int MR1_DLL_DIS = 0;
  localparam int MR1_RTT_B0  = 2;
  localparam int MR1_AL_LSB  = 3;
  localparam int MR1_RTT_B1  = 6;
  localparam int MR1_WLEV    = 7;
  localparam int MR1_RTT_B2  = 9;
  localparam int MR1_TERMINATION_STROBE_ENABLE    = 11;
  localparam int MR1_QOFF    = 12;
  localparam logic [ADDR_W-1:0] MR1_RSVD_MASK = 15'h6500;

  // Status bit positions
  localparam int ST_DLL_ON  = 0;
  localparam int ST_LOCKED  = 1;
  localparam int ST_DLLRST  = 2;
  localparam int ST_TEST    = 3;
  localparam int ST_RSVD    = 4;
  localparam int ST_RTT_BAD = 5;
  localparam int ST_AL_BAD  = 6;
  localparam int ST_BUSY    = 7;

  // Encodings
  localparam logic [2:0] MRS_BANK_MR0  = 3'h0;
  localparam logic [2:0] MRS_BANK_MR1  = 3'h1;
  localparam logic [1:0] BL_FIXED8     = 2'h0;
  localparam logic [1:0] BL_OTF        = 2'h1;
  localparam logic [1:0] BL_FIXED4     = 2'h2;
  localparam logic [1:0] AL_CL1        = 2'h1;
  localparam logic [1:0] AL_CL2        = 2'h2;
  localparam logic [1:0] AL_RSVD       = 2'h3;
  localparam logic [2:0] RTT_WRITE_MAX = 3'h3;

  // Latency and timing counts
  localparam logic [LAT_W-1:0] CL_BASE     = 6'h04;
  localparam logic [LAT_W-1:0] CL_HIGH_ADD = 6'h08;
  localparam logic [LAT_W-1:0] AL_ONE      = 6'h01;
  localparam logic [LAT_W-1:0] AL_TWO      = 6'h02;
  localparam logic [LAT_W-1:0] TRP_CYCLES  = 6'h06;
  localparam logic [LAT_W-1:0] LAT_FIRST   = 6'h01;
  localparam logic [LAT_W-1:0] LAT_TAIL    = 6'h02;
  localparam logic [2:0] BEAT_LAST      = 3'h7;
  localparam logic [2:0] WREF_BEAT_FULL = 3'h7;
  localparam logic [2:0] WREF_BEAT_CHOP = 3'h5;
  localparam int DLL_RESET_CYCLES = 8;
  localparam int DLL_LOCK_CYCLES  = 512;
  localparam logic [3:0] DLLRST_LAST   = 4'(DLL_RESET_CYCLES - 1);
  localparam logic [9:0] DLL_LOCK_LAST = 10'(DLL_LOCK_CYCLES);

  function automatic logic [LAT_W-1:0] cl_decode(input logic [ADDR_W-1:0] mr0);
    cl_decode = CL_BASE + {3'h0, mr0[MR0_CL_LSB +: 3]}
              + (mr0[MR0_CL_LO] ? CL_HIGH_ADD : 6'h00);
  endfunction

  function automatic logic [LAT_W-1:0] wr_decode(input logic [ADDR_W-1:0] mr0);
    case (mr0[MR0_WR_LSB +: 3])
      3'h1:    wr_decode = 6'h05;
      3'h2:    wr_decode = 6'h06;
      3'h3:    wr_decode = 6'h07;
      3'h4:    wr_decode = 6'h08;
      3'h5:    wr_decode = 6'h0A;
      3'h6:    wr_decode = 6'h0C;
      3'h7:    wr_decode = 6'h0E;
      default: wr_decode = 6'h10;
    endcase
  endfunction
endpackage

// ---- rtl/sdram_mode_register_decode.sv ----
/*
  Mode registers 0 and 1 of the memory device: command capture, field
  decode, burst sequencing, DLL reset/lock tracking and an APB view.
  Assumes command pins are synchronous to I_CLK_SYS and APB is a
  standard master on the same clock.
*/
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sdram_mode_register_decode
(
  // Clock, reset, enable
  input  wire logic                            I_CLK_SYS,
  input  wire logic                            I_RST_B,
  input  wire logic                            I_CE,
  // Command pins
  input  wire logic                            I_CS_B,
  input  wire logic                            I_RAS_B,
  input  wire logic                            I_CAS_B,
  input  wire logic                            I_WE_B,
  input  wire logic [2:0]                      I_BA,
  input  wire logic [ddr_mr_pkg::ADDR_W-1:0]   I_ADDR,
  // Power state
  input  wire logic                            I_SELF_REFRESH,
  input  wire logic                            I_PWR_DOWN,
  // APB
  input  wire logic                            I_PSEL,
  input  wire logic                            I_PENABLE,
  input  wire logic                            I_PWRITE,
  input  wire logic [ddr_mr_pkg::PADDR_W-1:0]  I_PADDR,
  input  wire logic [31:0]                     I_PWDATA,
  output logic      [31:0]                     O_PRDATA,
  output logic                                 O_PREADY,
  output logic                                 O_PSLVERR,
  // Burst beats
  output logic      [2:0]                      O_BEAT_COL,
  output logic                                 O_BEAT_VALID,
  output logic                                 O_DQ_OE,
  output logic                                 O_WRITE_REF,
  // Decoded state
  output logic                                 O_DLL_RESET,
  output logic                                 O_DLL_ON,
  output logic                                 O_DLL_LOCKED,
  output logic                                 O_PD_FAST_EXIT,
  output logic                                 O_TEST_MODE,
  output logic                                 O_TERM_STROBE_EN,
  output logic                                 O_WRITE_LEVEL,
  output logic      [ddr_mr_pkg::LAT_W-1:0]    O_READ_LATENCY,
  output logic      [ddr_mr_pkg::LAT_W-1:0]    O_DAL_CYCLES
);
  import ddr_mr_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_LAT, ST_BURST} seq_e;

  seq_e              st_reg;
  logic [ADDR_W-1:0] mr0_reg;
  logic [ADDR_W-1:0] mr1_reg;
  logic              ctrl_en_reg;
  logic [2:0]        beat_reg;
  logic [2:0]        start_reg;
  logic [LAT_W-1:0]  lat_reg;
  logic              chop_reg;
  logic              fixchop_reg;
  logic              wr_reg;
  logic              il_reg;
  logic [LAT_W-1:0]  cl_reg;
  logic [LAT_W-1:0]  al_reg;
  logic [LAT_W-1:0]  rl_reg;
  logic [LAT_W-1:0]  dal_reg;
  logic [3:0]        rst_cnt_reg;
  logic [9:0]        lock_cnt_reg;
  logic              dll_on_reg;
  logic              locked_reg;
  logic              valid_reg;
  logic              oe_reg;
  logic              wref_reg;
  logic              pready_reg;
  logic              pslverr_reg;
  logic [31:0]       prdata_reg;

  // Command decode
  wire is_mrs   = !I_CS_B && !I_RAS_B && !I_CAS_B && !I_WE_B;
  wire is_rd    = !I_CS_B && I_RAS_B && !I_CAS_B && I_WE_B;
  wire is_wr    = !I_CS_B && I_RAS_B && !I_CAS_B && !I_WE_B;
  wire mr0_load = is_mrs && (I_BA == MRS_BANK_MR0) && ctrl_en_reg;
  wire mr1_load = is_mrs && (I_BA == MRS_BANK_MR1) && ctrl_en_reg;
  wire accept   = (st_reg == ST_IDLE) && (is_rd || is_wr);
  wire [1:0] bl_mode  = mr0_reg[MR0_BL_LSB +: 2];
  wire       fix_chop = (bl_mode == BL_FIXED4);
  wire       cmd_chop = fix_chop || ((bl_mode == BL_OTF) && !I_ADDR[CMD_CHOP]);
  wire       in_burst = (st_reg == ST_BURST);
  wire       tail     = chop_reg && beat_reg[2];

  // Latency decode
  wire [1:0] al_code = mr1_reg[MR1_AL_LSB +: 2];
  wire [LAT_W-1:0] al_next = (al_code == AL_CL1) ? cl_reg - AL_ONE :
                             (al_code == AL_CL2) ? cl_reg - AL_TWO : 6'h00;

  // Configuration checks
  wire [2:0] rtt_nom  = {mr1_reg[MR1_RTT_B2], mr1_reg[MR1_RTT_B1], mr1_reg[MR1_RTT_B0]};
  wire       rtt_bad  = (rtt_nom > RTT_WRITE_MAX) && (!mr1_reg[MR1_WLEV] || !mr1_reg[MR1_QOFF]);
  wire       rsvd_bad = |(mr1_reg & MR1_RSVD_MASK);
  wire       dll_want = !mr1_reg[MR1_DLL_DIS] && !I_SELF_REFRESH
                        && !(I_PWR_DOWN && !mr0_reg[MR0_PPD]);
  wire       rst_done = mr0_reg[MR0_DLLRST] && (rst_cnt_reg == DLLRST_LAST);

  // APB decode
  wire apb_acc  = I_PSEL && I_PENABLE;
  wire apb_fire = apb_acc && pready_reg;
  wire hit_ctrl = (I_PADDR == OFF_CTRL);
  wire hit_any  = hit_ctrl || (I_PADDR == OFF_MR0) || (I_PADDR == OFF_MR1)
                  || (I_PADDR == OFF_STATUS) || (I_PADDR == OFF_LAT);
  wire [7:0] status = {st_reg != ST_IDLE, al_code == AL_RSVD, rtt_bad, rsvd_bad,
                       mr0_reg[MR0_TM], mr0_reg[MR0_DLLRST], locked_reg, dll_on_reg};
  wire [31:0] rd_data =
    hit_ctrl                 ? {31'h0000_0000, ctrl_en_reg} :
    (I_PADDR == OFF_MR0)     ? {17'h0_0000, mr0_reg} :
    (I_PADDR == OFF_MR1)     ? {17'h0_0000, mr1_reg} :
    (I_PADDR == OFF_STATUS)  ? {24'h00_0000, status} :
    (I_PADDR == OFF_LAT)     ? {2'h0, dal_reg, 2'h0, rl_reg, 2'h0, al_reg, 2'h0, cl_reg} :
                               32'h0000_0000;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      ctrl_en_reg <= CTRL_EN_RESET;
    end
    else if (I_CE)
    begin
      pready_reg  <= apb_acc && !pready_reg;
      pslverr_reg <= apb_acc && !pready_reg && !hit_any;
      prdata_reg  <= (apb_acc && !pready_reg && !I_PWRITE) ? rd_data : 32'h0000_0000;
      if (apb_fire && I_PWRITE && hit_ctrl)
        ctrl_en_reg <= I_PWDATA[0];
    end
  end

  // Mode registers; a new load wins over the self-clear
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      mr0_reg     <= MR_RESET;
      mr1_reg     <= MR_RESET;
      rst_cnt_reg <= 4'h0;
    end
    else if (I_CE)
    begin
      if (mr0_load)
        mr0_reg <= I_ADDR;
      else if (rst_done)
        mr0_reg[MR0_DLLRST] <= 1'b0;
      if (mr1_load)
        mr1_reg <= I_ADDR;
      rst_cnt_reg <= (mr0_load || !mr0_reg[MR0_DLLRST]) ? 4'h0 : rst_cnt_reg + 4'h1;
    end
  end

  // DLL enable and lock tracking
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      dll_on_reg   <= 1'b0;
      lock_cnt_reg <= 10'h000;
      locked_reg   <= 1'b0;
    end
    else if (I_CE)
    begin
      dll_on_reg <= dll_want;
      if (!dll_on_reg || mr0_reg[MR0_DLLRST])
        lock_cnt_reg <= 10'h000;
      else if (lock_cnt_reg != DLL_LOCK_LAST)
        lock_cnt_reg <= lock_cnt_reg + 10'h001;
      locked_reg <= dll_on_reg && !mr0_reg[MR0_DLLRST] && (lock_cnt_reg == DLL_LOCK_LAST);
    end
  end

  // Latency and recovery decode
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      cl_reg  <= CL_BASE;
      al_reg  <= 6'h00;
      rl_reg  <= CL_BASE;
      dal_reg <= 6'h00;
    end
    else if (I_CE)
    begin
      cl_reg  <= cl_decode(mr0_reg);
      al_reg  <= al_next;
      rl_reg  <= al_reg + cl_reg;
      dal_reg <= wr_decode(mr0_reg) + TRP_CYCLES;
    end
  end

  // Burst sequencer
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      st_reg      <= ST_IDLE;
      beat_reg    <= 3'h0;
      lat_reg     <= 6'h00;
      start_reg   <= 3'h0;
      chop_reg    <= 1'b0;
      fixchop_reg <= 1'b0;
      wr_reg      <= 1'b0;
      il_reg      <= 1'b0;
    end
    else if (I_CE)
    begin
      case (st_reg)
        ST_IDLE:
        begin
          beat_reg <= 3'h0;
          lat_reg  <= LAT_FIRST;
          if (accept)
          begin
            start_reg   <= I_ADDR[2:0];
            chop_reg    <= cmd_chop;
            fixchop_reg <= fix_chop;
            wr_reg      <= is_wr;
            il_reg      <= mr0_reg[MR0_BT];
            st_reg      <= is_wr ? ST_BURST : ST_LAT;
          end
        end
        ST_LAT:
        begin
          lat_reg <= lat_reg + LAT_FIRST;
          if (lat_reg == rl_reg - LAT_TAIL)
            st_reg <= ST_BURST;
        end
        ST_BURST:
        begin
          beat_reg <= beat_reg + 3'h1;
          if (beat_reg == BEAT_LAST)
            st_reg <= ST_IDLE;
        end
        default:
          st_reg <= ST_IDLE;
      endcase
    end
  end

  // Beat outputs
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      valid_reg <= 1'b0;
      oe_reg    <= 1'b0;
      wref_reg  <= 1'b0;
    end
    else if (I_CE)
    begin
      valid_reg <= in_burst && !tail;
      oe_reg    <= in_burst && !wr_reg && !tail && !mr1_reg[MR1_QOFF];
      wref_reg  <= in_burst && wr_reg
                   && (beat_reg == (fixchop_reg ? WREF_BEAT_CHOP : WREF_BEAT_FULL));
    end
  end

  burst_col_order u_col
  (
    .i_clk        (I_CLK_SYS),
    .i_rst_b      (I_RST_B),
    .i_ce         (I_CE),
    .i_start      (start_reg),
    .i_beat       (beat_reg),
    .i_interleave (il_reg),
    .i_write      (wr_reg),
    .i_chop       (chop_reg),
    .o_col        (O_BEAT_COL)
  );

  assign O_PRDATA         = prdata_reg;
  assign O_PREADY         = pready_reg;
  assign O_PSLVERR        = pslverr_reg;
  assign O_BEAT_VALID     = valid_reg;
  assign O_DQ_OE          = oe_reg;
  assign O_WRITE_REF      = wref_reg;
  assign O_DLL_RESET      = mr0_reg[MR0_DLLRST];
  assign O_DLL_ON         = dll_on_reg;
  assign O_DLL_LOCKED     = locked_reg;
  assign O_PD_FAST_EXIT   = mr0_reg[MR0_PPD];
  assign O_TEST_MODE      = mr0_reg[MR0_TM];
  assign O_TERM_STROBE_EN = mr1_reg[MR1_TERMINATION_STROBE_ENABLE];
  assign O_WRITE_LEVEL    = mr1_reg[MR1_WLEV];
  assign O_READ_LATENCY   = rl_reg;
  assign O_DAL_CYCLES     = dal_reg;

  // Checks assume I_CE stays high
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_B || !I_CE);

  a_mr0_load_value: assert property (mr0_load |=> mr0_reg == $past(I_ADDR))
    else $error("mode register 0 not loaded");
  a_mr1_load_value: assert property (mr1_load |=> mr1_reg == $past(I_ADDR))
    else $error("mode register 1 not loaded");
  a_otf_chop_pick: assert property (accept && bl_mode == BL_OTF |=> chop_reg == !$past(I_ADDR[CMD_CHOP]))
    else $error("on-the-fly chop wrongly sampled");
  a_interleave_col: assert property (in_burst && !wr_reg && il_reg |=> O_BEAT_COL == $past(start_reg ^ beat_reg))
    else $error("interleaved column wrong");
  a_write_col: assert property (in_burst && wr_reg && !chop_reg |=> O_BEAT_COL == $past(beat_reg))
    else $error("write column order wrong");
  a_chop_tail_off: assert property (in_burst && tail |=> !O_DQ_OE && !O_BEAT_VALID)
    else $error("chop tail slot driven");
  a_wref_fixed_chop: assert property (accept && is_wr && fix_chop |-> ##7 O_WRITE_REF)
    else $error("chop write reference not early");
  a_wref_full: assert property (accept && is_wr && !fix_chop |-> ##9 O_WRITE_REF)
    else $error("write reference time wrong");
  a_dll_self_clear: assert property ($rose(O_DLL_RESET) && !mr0_load |-> O_DLL_RESET [*8] ##1 !O_DLL_RESET)
    else $error("DLL reset did not self clear");
  a_qoff_no_drive: assert property (mr1_reg[MR1_QOFF] && $past(mr1_reg[MR1_QOFF]) |-> !O_DQ_OE)
    else $error("outputs driven while disconnected");
  a_read_first_beat: assert property (accept && is_rd && rl_reg == 6'h05 && $stable(rl_reg)
                                      |-> !O_BEAT_VALID [*5] ##1 O_BEAT_VALID)
    else $error("read latency wrong");

  c_chop_read: cover property (accept && is_rd && cmd_chop);
  c_otf_write: cover property (accept && is_wr && bl_mode == BL_OTF);
  c_dll_reset: cover property ($fell(O_DLL_RESET));
  c_il_read: cover property (in_burst && il_reg && !wr_reg);
endmodule
`default_nettype wire
